// [design/dct_coefficient_entropy_decoder.sv]
// Sequential entropy decoder producing zig-zag ordered signed coefficients.
`default_nettype none
module dct_coefficient_entropy_decoder (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scan_start,
	input wire logic restart_due,
	input wire logic block_start,
	input wire logic arith_mode,
	input wire logic [1:0] comp_sel,
	input wire logic [1:0] dc_sel,
	input wire logic [1:0] ac_sel,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready,
	input wire logic tbl_wr,
	input wire logic [2:0] tbl_sel,
	input wire logic [1:0] tbl_kind,
	input wire logic [7:0] tbl_addr,
	input wire logic [15:0] tbl_data,
	output logic bin_req,
	output logic [7:0] bin_ctx,
	output logic [2:0] bin_area,
	input wire logic bin_valid,
	input wire logic bin_value,
	output logic ctx_reset,
	output logic coef_valid,
	output logic [5:0] coef_index,
	output logic [15:0] coef_value,
	output logic block_busy,
	output logic block_done,
	output logic scan_end,
	output logic [15:0] line_count,
	output logic err_restart,
	output logic err_range,
	output logic err_marker
);
	entropy_pkg::dec_state_e state_q;
	logic [15:0] smallest_code_per_length [entropy_pkg::NUM_TABLES][entropy_pkg::NUM_LENGTHS];
	logic [15:0] largest_code_per_length [entropy_pkg::NUM_TABLES][entropy_pkg::NUM_LENGTHS];
	logic [7:0] value_index_per_length [entropy_pkg::NUM_TABLES][entropy_pkg::NUM_LENGTHS];
	logic [7:0] symbol_value_list [entropy_pkg::NUM_TABLES][entropy_pkg::NUM_SYMBOLS];
	logic [15:0] dc_predictor_q [entropy_pkg::NUM_COMPONENTS];
	logic is_ac_q, rst_first_q, neg_q, mark_prev_q, dc_predictor_clear_q;
	logic [1:0] comp_q, dc_tab_q, ac_tab_q;
	logic [5:0] k_q;
	logic [3:0] len_q, magnitude_category_q, zrun_q, rcnt_q, cstep_q;
	logic [15:0] code_q, raw_q, val_q, sz_q, mb_q;
	logic [7:0] idx_q;
	logic [2:0] expected_rst_q;
	logic f_clear, f_flush, f_take, f_bit_valid, f_bit, f_mark, f_line_valid;
	logic [7:0] f_code;
	logic [15:0] f_line;

	bit_fetcher bit_fetcher_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.clear(f_clear),
		.flush(f_flush),
		.byte_valid(byte_valid),
		.byte_data(byte_data),
		.byte_ready(byte_ready),
		.bit_take(f_take),
		.bit_valid(f_bit_valid),
		.bit_value(f_bit),
		.marker_valid(f_mark),
		.marker_code(f_code),
		.line_count(f_line),
		.line_count_valid(f_line_valid)
	);

	wire [1:0] tab_sel = is_ac_q ? ac_tab_q : dc_tab_q;
	wire [2:0] tab = {is_ac_q, tab_sel};
	wire [15:0] code_d = {code_q[14:0], f_bit};
	wire [15:0] max_here = largest_code_per_length[tab][len_q];
	wire code_hit = $signed({1'b0, code_d}) <= $signed({max_here[15], max_here});
	wire [15:0] idx_wide = 16'(value_index_per_length[tab][len_q]) + code_d - smallest_code_per_length[tab][len_q];
	wire [7:0] run_size_symbol = symbol_value_list[tab][idx_q];
	wire [3:0] zero_run_length = run_size_symbol[7:4];
	wire [3:0] magnitude_category = run_size_symbol[3:0];
	wire [15:0] raw_d = {raw_q[14:0], f_bit};
	wire [15:0] top_bit = 16'h0001 << magnitude_category_q;
	wire raw_pos = (raw_q & (top_bit >> 1)) != 16'h0000;
	wire [15:0] extended = (magnitude_category_q == 4'h0) ? 16'h0000 : (raw_pos ? raw_q : raw_q - top_bit + 16'h0001);
	wire [15:0] magnitude = sz_q + 16'h0001;
	wire [15:0] arith_val = neg_q ? 16'(-magnitude) : magnitude;
	wire [15:0] dc_predictor_sum = dc_predictor_q[comp_q] + val_q;
	wire [15:0] emit_val = is_ac_q ? val_q : dc_predictor_sum;
	wire at_end = k_q == entropy_pkg::SPECTRAL_END_INDEX;
	wire rst_ok = f_code[7:3] == entropy_pkg::RESTART_BASE && f_code[2:0] == expected_rst_q;
	wire mark_new = f_mark && !mark_prev_q;
	wire mark_is_rst = f_code[7:3] == entropy_pkg::RESTART_BASE;
	wire mark_ends = f_code == entropy_pkg::IMAGE_END_MARKER;
	wire mark_line = f_code == entropy_pkg::LINE_COUNT_MARKER;
	wire [7:0] se_ctx = 8'(3 * (k_q - 6'h01));
	wire [7:0] zero_ctx = is_ac_q ? se_ctx + 8'h01 : entropy_pkg::CTX_DC_ZERO;
	wire dec_state = state_q == entropy_pkg::S_AEOB || state_q == entropy_pkg::S_AZERO ||
		state_q == entropy_pkg::S_ASIGN || state_q == entropy_pkg::S_ACLASS ||
		(state_q == entropy_pkg::S_ABITS && mb_q != 16'h0000);
	wire got = bin_valid && dec_state;

	assign bin_req = dec_state;
	assign bin_area = tab;
	assign bin_ctx = (state_q == entropy_pkg::S_AEOB) ? se_ctx :
		(state_q == entropy_pkg::S_AZERO) ? zero_ctx :
		(state_q == entropy_pkg::S_ASIGN) ? (is_ac_q ? entropy_pkg::CTX_AC_SIGN : entropy_pkg::CTX_DC_SIGN) :
		(state_q == entropy_pkg::S_ACLASS) ? entropy_pkg::CTX_CLASS_BASE + 8'(cstep_q) :
		entropy_pkg::CTX_BITS_BASE + 8'(cstep_q);
	assign f_take = (state_q == entropy_pkg::S_HCODE) || (state_q == entropy_pkg::S_RECV && rcnt_q != 4'h0);
	assign f_flush = state_q == entropy_pkg::S_RST && rst_first_q;
	assign f_clear = scan_start || (state_q == entropy_pkg::S_RST && f_mark && rst_ok);
	assign block_busy = state_q != entropy_pkg::S_IDLE;

	// Table memories carry no reset; software must load them before a scan.
	always_ff @(posedge clk) begin
		if (tbl_wr) begin
			case (tbl_kind)
				entropy_pkg::KIND_SMALLEST: smallest_code_per_length[tbl_sel][tbl_addr[3:0]] <= tbl_data;
				entropy_pkg::KIND_LARGEST: largest_code_per_length[tbl_sel][tbl_addr[3:0]] <= tbl_data;
				entropy_pkg::KIND_INDEX: value_index_per_length[tbl_sel][tbl_addr[3:0]] <= tbl_data[7:0];
				default: symbol_value_list[tbl_sel][tbl_addr] <= tbl_data[7:0];
			endcase
		end
	end

	for (genvar g = 0; g < entropy_pkg::NUM_COMPONENTS; g++) begin : g_dc_predictor
		always_ff @(posedge clk) begin
			if (sys_rst || dc_predictor_clear_q) begin
				dc_predictor_q[g] <= 16'h0000;
			end else if (state_q == entropy_pkg::S_EMIT && !is_ac_q && comp_q == 2'(g)) begin
				dc_predictor_q[g] <= dc_predictor_sum;
			end
		end
	end

	always_ff @(posedge clk) begin
		coef_valid <= 1'b0;
		block_done <= 1'b0;
		scan_end <= 1'b0;
		ctx_reset <= 1'b0;
		err_restart <= 1'b0;
		err_range <= 1'b0;
		err_marker <= 1'b0;
		dc_predictor_clear_q <= 1'b0;
		if (sys_rst) begin
			state_q <= entropy_pkg::S_IDLE;
			coef_index <= 6'h00;
			coef_value <= 16'h0000;
			line_count <= 16'h0000;
			mark_prev_q <= 1'b0;
			expected_rst_q <= 3'h0;
			is_ac_q <= 1'b0;
			rst_first_q <= 1'b0;
			neg_q <= 1'b0;
			comp_q <= 2'h0;
			dc_tab_q <= 2'h0;
			ac_tab_q <= 2'h0;
			k_q <= 6'h00;
			len_q <= 4'h0;
			magnitude_category_q <= 4'h0;
			zrun_q <= 4'h0;
			rcnt_q <= 4'h0;
			cstep_q <= 4'h0;
			code_q <= 16'h0000;
			raw_q <= 16'h0000;
			val_q <= 16'h0000;
			sz_q <= 16'h0000;
			mb_q <= 16'h0000;
			idx_q <= 8'h00;
		end else if (scan_start) begin
			state_q <= entropy_pkg::S_IDLE;
			expected_rst_q <= 3'h0;
			ctx_reset <= 1'b1;
			dc_predictor_clear_q <= 1'b1;
			mark_prev_q <= 1'b0;
		end else if (f_line_valid) begin
			line_count <= f_line;
			scan_end <= 1'b1;
			state_q <= entropy_pkg::S_IDLE;
			mark_prev_q <= f_mark;
		end else begin
			mark_prev_q <= f_mark;
			if (mark_new && mark_ends) begin
				scan_end <= 1'b1;
				state_q <= entropy_pkg::S_IDLE;
			end else if (mark_new && !mark_is_rst && !mark_line) begin
				err_marker <= 1'b1;
			end
			case (state_q)
				entropy_pkg::S_IDLE: begin
					if (restart_due) begin
						state_q <= entropy_pkg::S_RST;
						rst_first_q <= 1'b1;
					end else if (block_start) begin
						comp_q <= comp_sel;
						dc_tab_q <= dc_sel;
						ac_tab_q <= ac_sel;
						is_ac_q <= 1'b0;
						k_q <= 6'h00;
						code_q <= 16'h0000;
						len_q <= 4'h0;
						state_q <= arith_mode ? entropy_pkg::S_AZERO : entropy_pkg::S_HCODE;
					end
				end
				entropy_pkg::S_HCODE: begin
					if (f_bit_valid) begin
						code_q <= code_d;
						idx_q <= idx_wide[7:0];
						len_q <= len_q + 4'h1;
						if (code_hit) begin
							state_q <= entropy_pkg::S_HLOOK;
						end else if (len_q == 4'hF) begin
							err_range <= 1'b1;
							state_q <= entropy_pkg::S_IDLE;
						end
					end
				end
				entropy_pkg::S_HLOOK: begin
					raw_q <= 16'h0000;
					magnitude_category_q <= magnitude_category;
					rcnt_q <= magnitude_category;
					zrun_q <= is_ac_q ? zero_run_length : 4'h0;
					if (!is_ac_q && zero_run_length != 4'h0) begin
						err_range <= 1'b1;
						state_q <= entropy_pkg::S_IDLE;
					end else if (is_ac_q && run_size_symbol == entropy_pkg::END_OF_BLOCK_SYMBOL) begin
						state_q <= entropy_pkg::S_FILL;
					end else if (is_ac_q && zero_run_length != 4'h0) begin
						state_q <= entropy_pkg::S_ZEROS;
					end else begin
						state_q <= entropy_pkg::S_RECV;
					end
				end
				entropy_pkg::S_ZEROS: begin
					coef_valid <= 1'b1;
					coef_index <= k_q;
					coef_value <= 16'h0000;
					zrun_q <= zrun_q - 4'h1;
					k_q <= k_q + 6'h01;
					if (at_end) begin
						err_range <= 1'b1;
						state_q <= entropy_pkg::S_IDLE;
					end else if (zrun_q == 4'h1) begin
						state_q <= entropy_pkg::S_RECV;
					end
				end
				entropy_pkg::S_RECV: begin
					if (rcnt_q == 4'h0) begin
						val_q <= extended;
						state_q <= entropy_pkg::S_EMIT;
					end else if (f_bit_valid) begin
						raw_q <= raw_d;
						rcnt_q <= rcnt_q - 4'h1;
					end
				end
				entropy_pkg::S_EMIT: begin
					coef_valid <= 1'b1;
					coef_index <= k_q;
					coef_value <= emit_val;
					code_q <= 16'h0000;
					len_q <= 4'h0;
					if (is_ac_q && at_end) begin
						block_done <= 1'b1;
						state_q <= entropy_pkg::S_IDLE;
					end else begin
						is_ac_q <= 1'b1;
						k_q <= is_ac_q ? k_q + 6'h01 : entropy_pkg::FIRST_AC_INDEX;
						state_q <= arith_mode ? entropy_pkg::S_AEOB : entropy_pkg::S_HCODE;
					end
				end
				entropy_pkg::S_FILL: begin
					coef_valid <= 1'b1;
					coef_index <= k_q;
					coef_value <= 16'h0000;
					k_q <= k_q + 6'h01;
					if (at_end) begin
						block_done <= 1'b1;
						state_q <= entropy_pkg::S_IDLE;
					end
				end
				entropy_pkg::S_AEOB: begin
					if (got) begin
						state_q <= bin_value ? entropy_pkg::S_FILL : entropy_pkg::S_AZERO;
					end
				end
				entropy_pkg::S_AZERO: begin
					if (got && bin_value) begin
						state_q <= entropy_pkg::S_ASIGN;
					end else if (got && !is_ac_q) begin
						val_q <= 16'h0000;
						state_q <= entropy_pkg::S_EMIT;
					end else if (got) begin
						coef_valid <= 1'b1;
						coef_index <= k_q;
						coef_value <= 16'h0000;
						k_q <= k_q + 6'h01;
						if (at_end) begin
							err_range <= 1'b1;
							state_q <= entropy_pkg::S_IDLE;
						end
					end
				end
				entropy_pkg::S_ASIGN: begin
					if (got) begin
						neg_q <= bin_value;
						mb_q <= 16'h0001;
						sz_q <= 16'h0000;
						cstep_q <= 4'h0;
						state_q <= entropy_pkg::S_ACLASS;
					end
				end
				entropy_pkg::S_ACLASS: begin
					if (got && bin_value) begin
						cstep_q <= cstep_q + 4'h1;
						mb_q <= {mb_q[14:0], 1'b0};
						if (mb_q[14]) begin
							err_range <= 1'b1;
							state_q <= entropy_pkg::S_IDLE;
						end
					end else if (got) begin
						sz_q <= mb_q >> 1;
						mb_q <= mb_q >> 2;
						state_q <= entropy_pkg::S_ABITS;
					end
				end
				entropy_pkg::S_ABITS: begin
					if (mb_q == 16'h0000) begin
						val_q <= arith_val;
						state_q <= entropy_pkg::S_EMIT;
					end else if (got) begin
						sz_q <= bin_value ? (sz_q | mb_q) : sz_q;
						mb_q <= mb_q >> 1;
					end
				end
				entropy_pkg::S_RST: begin
					rst_first_q <= 1'b0;
					if (f_mark) begin
						if (rst_ok) begin
							expected_rst_q <= expected_rst_q + 3'h1;
							ctx_reset <= 1'b1;
							dc_predictor_clear_q <= 1'b1;
						end else begin
							err_restart <= 1'b1;
						end
						state_q <= entropy_pkg::S_IDLE;
					end else if (!rst_first_q && f_bit_valid) begin
						err_restart <= 1'b1;
						state_q <= entropy_pkg::S_IDLE;
					end
				end
				default: state_q <= entropy_pkg::S_IDLE;
			endcase
		end
	end
endmodule : dct_coefficient_entropy_decoder
`default_nettype wire

// [design/entropy_pkg.sv]
// Constants and state encoding for the coefficient entropy decoder.
`default_nettype none
package entropy_pkg;
	localparam logic [7:0] MARKER_PREFIX = 8'hFF;
	localparam logic [7:0] STUFF_BYTE = 8'h00;
	localparam logic [4:0] RESTART_BASE = 5'h1A;
	localparam logic [7:0] LINE_COUNT_MARKER = 8'hDC;
	localparam logic [7:0] IMAGE_END_MARKER = 8'hD9;
	localparam logic [2:0] LINE_PAYLOAD_BYTES = 3'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int NUM_LENGTHS = 16;
	localparam int NUM_TABLES = 8;
	localparam int NUM_SYMBOLS = 256;
	localparam int NUM_COMPONENTS = 4;
	localparam logic [5:0] FIRST_AC_INDEX = 6'h01;
	localparam logic [5:0] SPECTRAL_END_INDEX = 6'h3F;
	localparam logic [7:0] END_OF_BLOCK_SYMBOL = 8'h00;
	localparam logic [1:0] KIND_SMALLEST = 2'h0;
	localparam logic [1:0] KIND_LARGEST = 2'h1;
	localparam logic [1:0] KIND_INDEX = 2'h2;
	localparam logic [1:0] KIND_VALUE = 2'h3;
	localparam logic [7:0] CTX_DC_ZERO = 8'h00;
	localparam logic [7:0] CTX_DC_SIGN = 8'h01;
	localparam logic [7:0] CTX_AC_SIGN = 8'hBD;
	localparam logic [7:0] CTX_CLASS_BASE = 8'hC0;
	localparam logic [7:0] CTX_BITS_BASE = 8'hD0;
	typedef enum logic [3:0] {
		S_IDLE, S_HCODE, S_HLOOK, S_ZEROS, S_RECV, S_EMIT, S_FILL,
		S_AEOB, S_AZERO, S_ASIGN, S_ACLASS, S_ABITS, S_RST
	} dec_state_e;
endpackage : entropy_pkg
`default_nettype wire

// [design/bit_fetcher.sv]
// Byte to bit fetcher with stuffing removal and marker capture.
`default_nettype none
module bit_fetcher (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic flush,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready,
	input wire logic bit_take,
	output logic bit_valid,
	output logic bit_value,
	output logic marker_valid,
	output logic [7:0] marker_code,
	output logic [15:0] line_count,
	output logic line_count_valid
);
	logic [7:0] shift_q;
	logic [3:0] bits_left_count_q;
	logic prefix_q;
	logic marker_q;
	logic [7:0] code_q;
	logic [2:0] payload_q;
	logic [15:0] line_q;
	logic line_valid_q;
	wire in_payload = payload_q != 3'h0;
	wire take = byte_valid && byte_ready;
	assign byte_ready = in_payload || (!marker_q && bits_left_count_q == 4'h0);
	assign bit_valid = !marker_q && bits_left_count_q != 4'h0;
	assign bit_value = shift_q[7];
	assign marker_valid = marker_q;
	assign marker_code = code_q;
	assign line_count = line_q;
	assign line_count_valid = line_valid_q;

	always_ff @(posedge clk) begin
		line_valid_q <= 1'b0;
		if (sys_rst || clear) begin
			bits_left_count_q <= 4'h0;
			shift_q <= 8'h00;
			prefix_q <= 1'b0;
			marker_q <= 1'b0;
			code_q <= 8'h00;
			payload_q <= 3'h0;
			if (sys_rst) begin
				line_q <= 16'h0000;
			end
		end else if (flush) begin
			bits_left_count_q <= 4'h0;
		end else if (take) begin
			if (in_payload) begin
				// Length bytes shift out; the last two left are the line count.
				line_q <= {line_q[7:0], byte_data};
				payload_q <= payload_q - 3'h1;
				line_valid_q <= payload_q == 3'h1;
			end else if (prefix_q) begin
				prefix_q <= byte_data == entropy_pkg::MARKER_PREFIX;
				if (byte_data == entropy_pkg::STUFF_BYTE) begin
					shift_q <= entropy_pkg::MARKER_PREFIX;
					bits_left_count_q <= entropy_pkg::BYTE_BITS;
				end else if (byte_data != entropy_pkg::MARKER_PREFIX) begin
					marker_q <= 1'b1;
					code_q <= byte_data;
					if (byte_data == entropy_pkg::LINE_COUNT_MARKER) begin
						payload_q <= entropy_pkg::LINE_PAYLOAD_BYTES;
					end
				end
			end else if (byte_data == entropy_pkg::MARKER_PREFIX) begin
				prefix_q <= 1'b1;
			end else begin
				shift_q <= byte_data;
				bits_left_count_q <= entropy_pkg::BYTE_BITS;
			end
		end else if (bit_take && bit_valid) begin
			shift_q <= {shift_q[6:0], 1'b0};
			bits_left_count_q <= bits_left_count_q - 4'h1;
		end
	end
endmodule : bit_fetcher
`default_nettype wire

// [tb/dct_coefficient_entropy_decoder_props.sv]
// Port-level checks for the coefficient entropy decoder.
`default_nettype none
module entropy_dec_props (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scan_start,
	input wire logic restart_due,
	input wire logic block_start,
	input wire logic arith_mode,
	input wire logic byte_ready,
	input wire logic bin_req,
	input wire logic [7:0] bin_ctx,
	input wire logic [2:0] bin_area,
	input wire logic bin_valid,
	input wire logic bin_value,
	input wire logic ctx_reset,
	input wire logic coef_valid,
	input wire logic [5:0] coef_index,
	input wire logic [15:0] coef_value,
	input wire logic block_busy,
	input wire logic block_done,
	input wire logic scan_end,
	input wire logic [15:0] line_count
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dcb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [5:0] last_idx_q;
	always_ff @(posedge clk) begin
		if (sys_rst) last_idx_q <= 6'h00;
		else if (coef_valid) last_idx_q <= coef_index;
	end
	sequence dc_zero_s;
		bin_req && bin_valid && !bin_area[2] && bin_ctx == entropy_pkg::CTX_DC_ZERO;
	endsequence
	sequence eob_taken_s;
		bin_req && bin_valid && bin_value && bin_area[2] && bin_ctx < 8'hBD && bin_ctx % 8'h03 == 8'h00;
	endsequence
	chk_ctx_on_scan: assert property (scan_start |-> ##[1:2] ctx_reset)
		else $error("no context reset after scan start");
	chk_done_at_last: assert property (block_done |-> coef_valid && coef_index == entropy_pkg::SPECTRAL_END_INDEX)
		else $error("block done away from last coefficient");
	chk_index_order: assert property (coef_valid && coef_index != 6'h00 |-> coef_index == last_idx_q + 6'h01)
		else $error("coefficient index out of order");
	chk_block_starts: assert property (block_start && !block_busy && !restart_due |=> block_busy)
		else $error("idle block start not taken");
	chk_first_zero: assert property (block_start && arith_mode && !block_busy && !restart_due |->
		##[1:4] bin_req && !bin_area[2] && bin_ctx == entropy_pkg::CTX_DC_ZERO)
		else $error("first decision is not the zero decision");
	chk_sign_follows: assert property (dc_zero_s and bin_value |=>
		##[0:3] bin_req && !bin_area[2] && bin_ctx == entropy_pkg::CTX_DC_SIGN)
		else $error("sign decision missing after non-zero");
	chk_no_sign: assert property (dc_zero_s and !bin_value |=>
		(!(bin_req && !bin_area[2] && bin_ctx == entropy_pkg::CTX_DC_SIGN))[*4])
		else $error("sign decoded for zero difference");
	chk_eob_fills_zero: assert property (eob_taken_s |=>
		(!bin_req && (!coef_valid || coef_value == 16'h0000))[*2])
		else $error("decoding went on after end of block");
	chk_restart_flush: assert property (restart_due && !block_busy |-> ##[1:3] byte_ready)
		else $error("partial byte kept over restart");
	chk_line_count_hold: assert property (!$past(sys_rst) && !$stable(line_count) |-> scan_end)
		else $error("line count changed without scan end");
endmodule : entropy_dec_props
bind dct_coefficient_entropy_decoder entropy_dec_props entropy_dec_props_inst (.*);
`default_nettype wire

// [tb/stream_partner.sv]
// Compressed byte source and binary decision answerer beside the decoder.
`default_nettype none
module stream_partner (
	input wire logic clk,
	input wire logic slow,
	input wire logic byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_data,
	input wire logic bin_req,
	input wire logic [7:0] bin_ctx,
	input wire logic [2:0] bin_area,
	output logic bin_valid,
	output logic bin_value
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] bq[$];
	logic dq[$];
	logic [10:0] log_q[$];
	logic took_b, took_d, waited;
	initial begin
		{byte_valid, byte_data, bin_valid, bin_value, waited} = 12'h000;
	end
	// Idle lines toggle so a design that reads them early never sees a stale value.
	always @(posedge clk) begin
		took_b = byte_valid && byte_ready;
		took_d = bin_valid && bin_req;
		waited = bin_req && !bin_valid;
		if (took_d) log_q.push_back({bin_area, bin_ctx});
		#2;
		if (took_b) bq.delete(0);
		if (took_d) dq.delete(0);
		byte_valid = bq.size() > 0;
		byte_data = byte_valid ? bq[0] : ~byte_data;
		bin_valid = dq.size() > 0 && (!slow || waited);
		bin_value = bin_valid ? dq[0] : ~bin_value;
	end
endmodule : stream_partner
`default_nettype wire

// [tb/dct_coefficient_entropy_decoder_tb.sv]
// Self-checking bench for the coefficient entropy decoder.
`default_nettype none
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module dct_coefficient_entropy_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] b; logic [15:0] d1; logic [15:0] d2;} row_s;
	row_s rows[4] = '{'{8'h60, 16'h0003, 16'h0000}, '{8'h20, 16'hFFFE, 16'hFFFB},
		'{8'h64, 16'h0003, 16'h0005}, '{8'h44, 16'h0002, 16'h0004}};
	int sel[4] = '{0, 3, 4, 7};
	int li[9] = '{0, 1, 2, 6, 7, 8, 10, 11, 12};
	logic [10:0] lv[9] = '{11'h200, 11'h201, 11'h2C0, 11'h700, 11'h701, 11'h7BD, 11'h703, 11'h200, 11'h700};
	int num_errors = 0, num_checks = 0, cycles = 0, done_cnt = 0, ctx_cnt = 0, err_cnt = 0, end_cnt = 0;
	int rg_cnt = 0, mk_cnt = 0;
	logic clk = 1'b0, sys_rst = 1'b1, scan_start, restart_due, block_start, arith_mode, tbl_wr, slow;
	logic [1:0] comp_sel, dc_sel, ac_sel, tbl_kind;
	logic [2:0] tbl_sel, bin_area;
	logic [7:0] tbl_addr, byte_data, bin_ctx;
	logic [15:0] tbl_data, coef_value, line_count;
	logic byte_ready, byte_valid, bin_req, bin_valid, bin_value, ctx_reset, coef_valid;
	logic block_busy, block_done, scan_end, err_restart, err_range, err_marker;
	logic [5:0] coef_index;
	logic [5:0] ci[$];
	logic [15:0] cv[$];
	dct_coefficient_entropy_decoder dct_coefficient_entropy_decoder_inst (.*);
	stream_partner stream_partner_inst (.*);
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic tally_and_finish();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish
	// The ceiling sits far above the fewer than two thousand cycles that the sequence needs.
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			tally_and_finish();
		end
		if (coef_valid === 1'b1) begin
			ci.push_back(coef_index);
			cv.push_back(coef_value);
		end
		done_cnt += int'(block_done === 1'b1);
		ctx_cnt += int'(ctx_reset === 1'b1);
		err_cnt += int'(err_restart === 1'b1);
		end_cnt += int'(scan_end === 1'b1);
		rg_cnt += int'(err_range === 1'b1);
		mk_cnt += int'(err_marker === 1'b1);
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick
	task automatic wr(input int s, input int k, input int a, input logic [15:0] d);
		tbl_wr = 1'b1;
		tbl_sel = 3'(s);
		tbl_kind = 2'(k);
		tbl_addr = 8'(a);
		tbl_data = d;
		tick(1);
	endtask : wr
	task automatic new_scan();
		scan_start = 1'b1;
		tick(1);
		scan_start = 1'b0;
		tick(1);
	endtask : new_scan
	task automatic run_block();
		int n;
		n = done_cnt;
		block_start = 1'b1;
		tick(1);
		block_start = 1'b0;
		while (done_cnt == n) tick(1);
	endtask : run_block
	task automatic check_blk(input logic [15:0] dc, input logic [15:0] a1);
		`CHECK(ci.size(), 64)
		for (int i = 0; i < ci.size(); i++) begin
			`CHECK(ci[i], 6'(i))
			`CHECK(cv[i], i == 0 ? dc : i == 1 ? a1 : 16'h0000)
		end
		ci.delete();
		cv.delete();
	endtask : check_blk
	task automatic restart(input logic [2:0] num);
		restart_due = 1'b1;
		tick(1);
		restart_due = 1'b0;
		tick(2);
		stream_partner_inst.bq = '{8'hFF, {entropy_pkg::RESTART_BASE, num}};
		tick(12);
	endtask : restart
	initial begin
		logic [15:0] m;
		{scan_start, restart_due, block_start, arith_mode, tbl_wr, slow} = 6'h00;
		{comp_sel, dc_sel, ac_sel, tbl_sel, tbl_kind, tbl_addr, tbl_data} = 35'h0;
		tick(5);
		sys_rst = 1'b0;
		`CHECK(byte_ready, 1'b1)
		`CHECK(block_busy, 1'b0)
		// One code of length one per table, plus a length-eight code in the difference tables.
		for (int t = 0; t < 4; t++) begin
			for (int i = 0; i < 16; i++) begin
				m = i == 0 ? 16'h0000 : (t < 2 && i == 7) ? 16'h00FF : 16'hFFFF;
				wr(sel[t], 0, i, m);
				wr(sel[t], 1, i, m);
				wr(sel[t], 2, i, i == 7 ? 16'h0001 : 16'h0000);
			end
			wr(sel[t], 3, 0, t < 2 ? 16'h0002 : 16'h0000);
			wr(sel[t], 3, 1, 16'h0000);
		end
		tbl_wr = 1'b0;
		foreach (rows[r]) begin
			new_scan();
			dc_sel = 2'(3 * (r % 2));
			ac_sel = dc_sel;
			stream_partner_inst.bq.push_back(rows[r].b);
			run_block();
			check_blk(rows[r].d1, 16'h0000);
			run_block();
			check_blk(rows[r].d2, 16'h0000);
		end
		`CHECK(ctx_cnt, 4)
		new_scan();
		stream_partner_inst.bq = '{8'hFF, 8'h00, 8'h30};
		run_block();
		check_blk(16'h0000, 16'h0000);
		run_block();
		check_blk(16'h0003, 16'h0000);
		restart(3'h0);
		`CHECK(ctx_cnt, 6)
		`CHECK(err_cnt, 0)
		stream_partner_inst.bq = '{8'h60};
		run_block();
		check_blk(16'h0003, 16'h0000);
		restart(3'h3);
		`CHECK(err_cnt, 1)
		new_scan();
		stream_partner_inst.bq = '{8'hFF, entropy_pkg::LINE_COUNT_MARKER, 8'h00, 8'h04, 8'h01, 8'h23};
		tick(12);
		`CHECK(end_cnt, 1)
		`CHECK(line_count, 16'h0123)
		new_scan();
		stream_partner_inst.bq = '{8'hFF, 8'hE5};
		tick(8);
		`CHECK(mk_cnt, 1)
		new_scan();
		stream_partner_inst.bq = '{8'hFF, entropy_pkg::IMAGE_END_MARKER};
		tick(8);
		`CHECK(end_cnt, 2)
		new_scan();
		arith_mode = 1'b1;
		comp_sel = 2'h1;
		dc_sel = 2'h2;
		ac_sel = 2'h3;
		stream_partner_inst.dq = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
		run_block();
		check_blk(16'hFFFC, 16'h0001);
		slow = 1'b1;
		stream_partner_inst.dq = '{1'b0, 1'b1};
		run_block();
		check_blk(16'hFFFC, 16'h0000);
		`CHECK(stream_partner_inst.log_q.size(), 13)
		foreach (li[j]) `CHECK(stream_partner_inst.log_q[li[j]], lv[j])
		// Fifteen class ones push the bound past bit 14, so the block must give up.
		stream_partner_inst.dq = '{1'b1, 1'b0};
		repeat (15) stream_partner_inst.dq.push_back(1'b1);
		block_start = 1'b1;
		tick(1);
		block_start = 1'b0;
		tick(60);
		`CHECK(rg_cnt, 1)
		`CHECK(block_busy, 1'b0)
		// A block left waiting for data must be abandoned by a reset.
		arith_mode = 1'b0;
		block_start = 1'b1;
		tick(1);
		block_start = 1'b0;
		tick(3);
		`CHECK(block_busy, 1'b1)
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		tick(1);
		`CHECK(block_busy, 1'b0)
		`CHECK(line_count, 16'h0000)
		`CHECK(byte_ready, 1'b1)
		// A length-two code for run two, category one, puts zeros ahead of a value.
		wr(4, 0, 1, 16'h0002);
		wr(4, 1, 1, 16'h0002);
		wr(4, 2, 1, 16'h0001);
		wr(4, 3, 1, 16'h0021);
		tbl_wr = 1'b0;
		{dc_sel, ac_sel} = 4'h0;
		stream_partner_inst.bq = '{8'h74};
		run_block();
		`CHECK(cv[3], 16'h0001)
		cv[3] = 16'h0000;
		check_blk(16'h0003, 16'h0000);
		tally_and_finish();
	end
endmodule : dct_coefficient_entropy_decoder_tb
`default_nettype wire
